/* bench/accel_power_cfg_checker.sv */
// Concurrent checks on the ports of the power and configuration block.
// Assumes the single clock and the active-low asynchronous reset.
`timescale 1ns/100ps
module accel_power_cfg_checker (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire accel_cfg_pkg::reg_req_t i_req,
	input wire logic i_level_pose_raw,
	input wire accel_cfg_pkg::power_mode_t o_power_mode,
	input wire logic o_fast_access_profile,
	input wire logic o_fifo_access_en,
	input wire logic o_slow_write_required,
	input wire logic o_equidistant_timebase,
	input wire logic o_fifo_write,
	input wire logic o_soft_reset_busy,
	input wire accel_cfg_pkg::engine_enable_t o_engine_enable,
	input wire logic o_level_pose_flag
);
	import accel_cfg_pkg::*;
	logic pm_wr, wr_ok, key_wr, legal;
	// Writes during a soft reset are not judged; profile and enable writes are not judged in deep sleep either
	assign pm_wr = i_req.wr && !o_soft_reset_busy && i_req.addr == POWER_MODE_SELECT;
	assign wr_ok = i_req.wr && !o_soft_reset_busy && o_power_mode != PM_DEEP_SLEEP;
	assign key_wr = i_req.wr && !o_soft_reset_busy && i_req.addr == SOFTWARE_RESET_KEY;
	assign legal = i_req.wdata[7:5] inside {3'b000, 3'b001, 3'b010, 3'b100};
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	mode_legal_a: assert property (pm_wr && legal |=> o_power_mode == $past(i_req.wdata[7:5]))
		else $error("legal mode not applied");
	mode_hold_a: assert property (pm_wr && !legal |=> $stable(o_power_mode))
		else $error("illegal mode changed state");
	saving_prof_a: assert property (!o_fast_access_profile && o_power_mode inside {PM_LOW_POWER, PM_SUSPEND}
		|-> !o_fifo_access_en && o_slow_write_required) else $error("deep saving outputs wrong");
	fast_prof_a: assert property (o_fast_access_profile |-> o_fifo_access_en && !o_slow_write_required)
		else $error("fast access outputs wrong");
	lp_bits_a: assert property (wr_ok && i_req.addr == LOW_POWER_PROFILE |=>
		o_equidistant_timebase == $past(i_req.wdata[5]) && o_fast_access_profile == $past(i_req.wdata[6]))
		else $error("profile bits not applied");
	no_fifo_a: assert property (o_power_mode == PM_SUSPEND ##1 o_power_mode == PM_SUSPEND |-> !o_fifo_write)
		else $error("fifo write in suspend");
	key_go_a: assert property (key_wr && i_req.wdata == RESET_KEY |=> o_soft_reset_busy)
		else $error("key did not start reset");
	key_ignore_a: assert property (key_wr && i_req.wdata != RESET_KEY |=> !o_soft_reset_busy)
		else $error("wrong key started reset");
	reset_done_a: assert property ($fell(o_soft_reset_busy) |-> o_power_mode == PM_NORMAL &&
		o_engine_enable == '0 && !o_fast_access_profile) else $error("defaults not restored");
	enable_map_a: assert property (wr_ok && i_req.addr == EVENT_ENABLE_GROUP0 |=>
		o_engine_enable == {$past(i_req.wdata[7:4]), $past(i_req.wdata[2:0])}) else $error("enable map");
	pose_flag_a: assert property (o_level_pose_flag == (i_level_pose_raw && o_engine_enable.level_pose))
		else $error("level pose flag not gated");
endmodule // accel_power_cfg_checker

bind accel_power_cfg accel_power_cfg_checker u_chk (.i_clock, .i_arst_n, .i_req, .i_level_pose_raw,
	.o_power_mode, .o_fast_access_profile, .o_fifo_access_en, .o_slow_write_required,
	.o_equidistant_timebase, .o_fifo_write, .o_soft_reset_busy, .o_engine_enable, .o_level_pose_flag);

/* bench/cfg_host_model.sv */
// Host processor model issuing register requests to the configuration block.
// Assumes one-cycle strobes and read data valid the edge after the read.
`timescale 1ns/100ps
module cfg_host_model (
	input wire logic i_clock,
	input wire logic [7:0] i_reg_rdata,
	output accel_cfg_pkg::reg_req_t o_req
);
	import accel_cfg_pkg::*;
	initial o_req = '0;
	// An idle cycle between requests keeps the pace legal in every profile
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clock) #1;
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge i_clock) #1;
		o_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clock) #1;
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clock) #1;
		o_req = '0;
		v = i_reg_rdata;
	endtask
	task automatic set_mode(input logic [7:0] v);
		wr(POWER_MODE_SELECT, 8'h00);
		wr(POWER_MODE_SELECT, v);
	endtask
	task automatic restore(input logic [7:0] en);
		wr(EVENT_ENABLE_GROUP0, en);
	endtask
endmodule // cfg_host_model

/* bench/test_power_mode_and_config_regs.sv */
// Self-checking bench for the power and configuration register block.
// Assumes the host model drives all register traffic.
`timescale 1ns/100ps
module test_power_mode_and_config_regs;
	import accel_cfg_pkg::*;
	logic clk = 0, arst_n = 0, eight = 0, sv = 0, raw = 0;
	int fails = 0, checks = 0, seed = 32'h7bcf0433, t;
	reg_req_t req;
	accel_sample_t smp = '0;
	power_mode_t pm;
	engine_enable_t en;
	logic [7:0] rdata, d, r;
	logic [11:0] x;
	logic fast, fae, slow, eqt, wake, fw, busy, lpf, lpv;
	always #5 clk = ~clk;
	cfg_host_model u_host (.i_clock(clk), .i_reg_rdata(rdata), .o_req(req));
	accel_power_cfg #(.CYCLES_PER_US(1)) u_dut (.i_clock(clk), .i_arst_n(arst_n), .i_req(req),
		.o_reg_rdata(rdata), .i_eight_bit_mode(eight), .i_sample_valid(sv), .i_sample(smp),
		.i_level_pose_raw(raw), .o_power_mode(pm), .o_fast_access_profile(fast),
		.o_fifo_access_en(fae), .o_slow_write_required(slow), .o_equidistant_timebase(eqt),
		.o_wake_pulse(wake), .o_fifo_write(fw), .o_soft_reset_busy(busy),
		.o_engine_enable(en), .o_level_pose_flag(lpf), .o_level_pose_valid(lpv));
	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic push;
		@(posedge clk) #1;
		smp = accel_sample_t'({$random(seed), $random(seed), $random(seed)});
		sv = 1;
		@(posedge clk) #1;
		sv = 0;
	endtask
	function automatic logic [2:0] mode_of(input logic [2:0] c);
		return (c inside {3'b000, 3'b001, 3'b010, 3'b100}) ? c : 3'b000;
	endfunction
	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		end_of_test;
	end
	// ==========================================
	// Tests
	initial begin
		repeat (3) @(posedge clk);
		#1 arst_n = 1;
		for (int c = 0; c < 8; c++) begin
			r = {c[2:0], 5'($random(seed))};
			u_host.set_mode(r);
			chk(pm, mode_of(c[2:0]));
			chk_rd(POWER_MODE_SELECT, r & 8'hfe);
		end
		u_host.set_mode(8'h40);
		u_host.wr(POWER_MODE_SELECT, 8'hc0);
		chk(pm, PM_LOW_POWER);
		$display("test modes done");
		foreach (SLEEP_US[c]) if (c < 8 && c > 4 || c == 0) begin
			u_host.set_mode({3'b010, 4'(c), 1'b0});
			repeat (2) begin
				t = 0;
				do begin @(negedge clk); t++; end while (wake !== 1'b1 && t < 3000);
			end
			chk(t, SLEEP_US[c]);
		end
		$display("test sleep done");
		for (int p = 0; p < 4; p++) begin
			u_host.set_mode(p[1] ? 8'h80 : 8'h40);
			r = 8'($random(seed));
			r[6] = p[0];
			u_host.wr(LOW_POWER_PROFILE, r);
			repeat (4) push;
			chk({fast, eqt, fae, slow}, {r[6], r[5], r[6], ~r[6]});
			chk_rd(LOW_POWER_PROFILE, r & 8'h60);
		end
		$display("test profile done");
		u_host.set_mode(8'h00);
		for (int a = 0; a < 3; a++) begin
			u_host.wr(OUTPUT_DATA_FORMAT, 8'h80);
			push;
			x = smp.unfiltered[a];
			chk_rd(ACCEL_DATA_BASE + 8'(2 * a), {x[3:0], 4'h0});
			push;
			chk_rd(ACCEL_DATA_BASE + 8'(2 * a + 1), x[11:4]);
			// Released MSB follows only samples that arrive after the release
			push;
			chk_rd(ACCEL_DATA_BASE + 8'(2 * a + 1), smp.unfiltered[a][11:4]);
			u_host.wr(OUTPUT_DATA_FORMAT, 8'h40);
			push;
			chk_rd(ACCEL_DATA_BASE + 8'(2 * a), {smp.filtered[a][3:0], 4'h0});
			push;
			chk_rd(ACCEL_DATA_BASE + 8'(2 * a + 1), smp.filtered[a][11:4]);
		end
		$display("test shadow done");
		for (int i = 0; i < 5; i++) begin
			r = i == 0 ? 8'hff : 8'($random(seed));
			u_host.wr(EVENT_ENABLE_GROUP0, r);
			chk(en, {r[7:4], r[2:0]});
			chk_rd(EVENT_ENABLE_GROUP0, r & 8'hf7);
			raw = 1;
			#1 chk({lpf, lpv}, {r[7], r[7]});
			raw = 0;
		end
		$display("test enables done");
		u_host.set_mode(8'h40);
		u_host.wr(SOFTWARE_RESET_KEY, 8'h5a);
		chk(busy, 1'b0);
		eight = 1;
		u_host.wr(SOFTWARE_RESET_KEY, RESET_KEY);
		t = 0;
		// One negedge per busy cycle, starting inside the first busy cycle
		@(negedge clk);
		while (busy === 1'b1 && t < 400) begin @(negedge clk); t++; end
		chk(t, SOFT_RESET_CYCLES);
		repeat (5) @(posedge clk);
		chk(pm, PM_NORMAL);
		chk_rd(EVENT_ENABLE_GROUP0, 8'h00);
		chk_rd(OUTPUT_DATA_FORMAT, 8'h40);
		chk_rd(SOFTWARE_RESET_KEY, 8'h00);
		chk_rd(8'h15, 8'h00);
		u_host.restore(8'h84);
		chk(en, 7'h44);
		$display("test reset done");
		end_of_test;
	end
endmodule // test_power_mode_and_config_regs

/* core/accel_cfg_pkg.sv */
// Constants, types and the field map of the power and configuration registers.
// Assumes a 100 MHz single clock and a byte-wide internal register port.
//
// What this block does
// - Decode bits 7:5 into power mode
// - Sleep interval code sets low-power sleep length
// - Profile bit 0: deep saving, FIFO blocked in low-power and suspend
// - Profile bit 1: fast access, full speed
// - Time-base bit picks event or equidistant
// - Equal FIFO spacing only with equidistant base
// - Output-select bit picks unfiltered or filtered data
// - Lock-disable bit, reset 1 in 8-bit mode
// - LSB read freezes matching MSB register
// - MSB read releases the freeze
// - Key 0xb6 starts software reset, others ignored
// - After delay, all settings return to defaults
// - Software reset works in every mode
// - Bits 7:4 enable pose, change, knock engines
// - Bits 2:0 enable slope detection z, y, x
// - Level-pose flag valid only while enabled
package accel_cfg_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] POWER_MODE_SELECT = 8'h11;
	localparam logic [7:0] LOW_POWER_PROFILE = 8'h12;
	localparam logic [7:0] OUTPUT_DATA_FORMAT = 8'h13;
	localparam logic [7:0] SOFTWARE_RESET_KEY = 8'h14;
	localparam logic [7:0] EVENT_ENABLE_GROUP0 = 8'h16;
	// Acceleration data pairs, LSB then MSB per axis, x first
	localparam logic [7:0] ACCEL_DATA_BASE = 8'h02;

	// ==========================================
	// Fields and reset values
	localparam int PM_HI = 7;
	localparam int PM_LO = 5;
	localparam int SLEEP_HI = 4;
	localparam int SLEEP_LO = 1;
	localparam int PROFILE_BIT = 6;
	localparam int TIMEBASE_BIT = 5;
	localparam int UNFILT_BIT = 7;
	localparam int LOCK_DIS_BIT = 6;
	localparam logic [7:0] POWER_MASK = 8'hfe;
	localparam logic [7:0] PROFILE_MASK = 8'h60;
	localparam logic [7:0] FORMAT_MASK = 8'hc0;
	localparam logic [7:0] ENABLE_MASK = 8'hf7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RESET_KEY = 8'hb6;

	// ==========================================
	// Timing
	localparam int CLOCK_MHZ = 100;
	localparam int SOFT_RESET_DELAY_US = 2;
	localparam int SOFT_RESET_CYCLES = SOFT_RESET_DELAY_US * CLOCK_MHZ;
	localparam int STRAP_SETTLE = 3;

	// Sleep-phase length in microseconds for each interval code
	localparam logic [19:0] SLEEP_US [16] = '{
		20'd500, 20'd500, 20'd500, 20'd500, 20'd500, 20'd500,
		20'd1000, 20'd2000, 20'd4000, 20'd6000, 20'd10000,
		20'd25000, 20'd50000, 20'd100000, 20'd500000, 20'd1000000};

	typedef enum logic [2:0] {
		PM_NORMAL = 3'b000,
		PM_DEEP_SLEEP = 3'b001,
		PM_LOW_POWER = 3'b010,
		PM_SUSPEND = 3'b100
	} power_mode_t;

	typedef logic [11:0] axis_t;

	typedef struct packed {
		axis_t [2:0] filtered;
		axis_t [2:0] unfiltered;
	} accel_sample_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic level_pose;
		logic pose_change;
		logic single_knock;
		logic double_knock;
		logic [2:0] slope_zyx;
	} engine_enable_t;

endpackage

/* core/accel_power_cfg.sv */
// Power mode, low-power profile, output format, keyed reset and engine enables.
// Assumes a single-cycle register port from the serial front end on i_clock
// and acceleration samples from logic on the same clock.
`timescale 1ns/100ps

module accel_power_cfg #(
	parameter int CYCLES_PER_US = accel_cfg_pkg::CLOCK_MHZ
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire accel_cfg_pkg::reg_req_t i_req,
	output logic [7:0] o_reg_rdata,
	input wire logic i_eight_bit_mode,
	input wire logic i_sample_valid,
	input wire accel_cfg_pkg::accel_sample_t i_sample,
	input wire logic i_level_pose_raw,
	output accel_cfg_pkg::power_mode_t o_power_mode,
	output logic o_fast_access_profile,
	output logic o_fifo_access_en,
	output logic o_slow_write_required,
	output logic o_equidistant_timebase,
	output logic o_wake_pulse,
	output logic o_fifo_write,
	output logic o_soft_reset_busy,
	output accel_cfg_pkg::engine_enable_t o_engine_enable,
	output logic o_level_pose_flag,
	output logic o_level_pose_valid
);
	import accel_cfg_pkg::*;

	// ==========================================
	// Strap synchroniser
	logic strap_meta_r;
	logic strap_sync_r;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_meta_r <= 1'b0;
			strap_sync_r <= 1'b0;
		end else begin
			strap_meta_r <= i_eight_bit_mode;
			strap_sync_r <= strap_meta_r;
		end
	end

	// ==========================================
	// Configuration registers
	logic [7:0] power_r, power_nxt;
	logic [7:0] profile_r, profile_nxt;
	logic [7:0] format_r, format_nxt;
	logic [7:0] enable_r, enable_nxt;
	power_mode_t mode_r, mode_nxt;
	logic [1:0] settle_r, settle_nxt;
	logic [15:0] srst_cnt_r, srst_cnt_nxt;
	logic srst_busy_r, srst_busy_nxt;
	logic [2:0] code;
	logic srst_done;

	assign code = i_req.wdata[PM_HI:PM_LO];
	assign srst_done = srst_busy_r && (srst_cnt_r == 16'h0000);

	always_comb begin
		power_nxt = power_r;
		profile_nxt = profile_r;
		format_nxt = format_r;
		enable_nxt = enable_r;
		mode_nxt = mode_r;
		settle_nxt = settle_r;
		srst_cnt_nxt = srst_cnt_r;
		srst_busy_nxt = srst_busy_r;
		if (i_req.wr) begin
			if (i_req.addr == POWER_MODE_SELECT) begin
				power_nxt = i_req.wdata & POWER_MASK;
				case (code)
					PM_NORMAL, PM_DEEP_SLEEP, PM_LOW_POWER, PM_SUSPEND: begin
						mode_nxt = power_mode_t'(code);
					end
					default: begin
						// Stored for readback, but the running mode stays
						mode_nxt = mode_r;
					end
				endcase
			end else if (i_req.addr == LOW_POWER_PROFILE) begin
				profile_nxt = i_req.wdata & PROFILE_MASK;
			end else if (i_req.addr == OUTPUT_DATA_FORMAT) begin
				format_nxt = i_req.wdata & FORMAT_MASK;
			end else if (i_req.addr == EVENT_ENABLE_GROUP0) begin
				enable_nxt = i_req.wdata & ENABLE_MASK;
			end else if (i_req.addr == SOFTWARE_RESET_KEY) begin
				// No mode gating: the key works in every power mode
				if (i_req.wdata == RESET_KEY) begin
					srst_busy_nxt = 1'b1;
					srst_cnt_nxt = 16'(SOFT_RESET_CYCLES - 1);
				end
			end
		end
		if (srst_busy_r && !srst_done) begin
			srst_cnt_nxt = srst_cnt_r - 16'h0001;
		end
		if (mode_nxt == PM_DEEP_SLEEP && mode_r != PM_DEEP_SLEEP) begin
			// Deepest sleep does not hold the application settings
			profile_nxt = REG_RESET;
			format_nxt = REG_RESET;
			enable_nxt = REG_RESET;
			settle_nxt = 2'(STRAP_SETTLE);
		end
		if (srst_done) begin
			power_nxt = REG_RESET;
			profile_nxt = REG_RESET;
			format_nxt = REG_RESET;
			enable_nxt = REG_RESET;
			mode_nxt = PM_NORMAL;
			srst_busy_nxt = 1'b0;
			settle_nxt = 2'(STRAP_SETTLE);
		end
		if (settle_r != 2'h0) begin
			settle_nxt = settle_r - 2'h1;
			if (settle_r == 2'h1) begin
				// Strap is valid only after passing the synchroniser
				format_nxt[LOCK_DIS_BIT] = strap_sync_r;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			power_r <= REG_RESET;
			profile_r <= REG_RESET;
			format_r <= REG_RESET;
			enable_r <= REG_RESET;
			mode_r <= PM_NORMAL;
			settle_r <= 2'(STRAP_SETTLE);
			srst_cnt_r <= 16'h0000;
			srst_busy_r <= 1'b0;
		end else begin
			power_r <= power_nxt;
			profile_r <= profile_nxt;
			format_r <= format_nxt;
			enable_r <= enable_nxt;
			mode_r <= mode_nxt;
			settle_r <= settle_nxt;
			srst_cnt_r <= srst_cnt_nxt;
			srst_busy_r <= srst_busy_nxt;
		end
	end

	// ==========================================
	// Low-power sleep timer
	logic [26:0] sleep_cnt_r, sleep_cnt_nxt;
	logic wake_r, wake_nxt;
	logic fifo_wr_r, fifo_wr_nxt;
	logic [26:0] sleep_len;
	logic equidistant;

	assign sleep_len = 27'(SLEEP_US[power_r[SLEEP_HI:SLEEP_LO]] * CYCLES_PER_US);
	assign equidistant = profile_r[TIMEBASE_BIT];

	always_comb begin
		sleep_cnt_nxt = sleep_cnt_r;
		wake_nxt = 1'b0;
		fifo_wr_nxt = 1'b0;
		if (mode_r == PM_LOW_POWER) begin
			if (sleep_cnt_r == 27'h0000000) begin
				wake_nxt = 1'b1;
				sleep_cnt_nxt = sleep_len - 27'h0000001;
			end else begin
				sleep_cnt_nxt = sleep_cnt_r - 27'h0000001;
			end
			if (equidistant) begin
				fifo_wr_nxt = wake_nxt;
			end else begin
				fifo_wr_nxt = i_sample_valid;
			end
		end else begin
			sleep_cnt_nxt = 27'h0000000;
			fifo_wr_nxt = i_sample_valid && mode_r == PM_NORMAL;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sleep_cnt_r <= 27'h0000000;
			wake_r <= 1'b0;
			fifo_wr_r <= 1'b0;
		end else begin
			sleep_cnt_r <= sleep_cnt_nxt;
			wake_r <= wake_nxt;
			fifo_wr_r <= fifo_wr_nxt;
		end
	end

	// ==========================================
	// Acceleration data and shadow lock
	axis_t [2:0] live_r, live_nxt;
	logic [2:0][7:0] msb_r, msb_nxt;
	logic [2:0] lock_r, lock_nxt;
	axis_t [2:0] src;
	logic [7:0] rel;

	assign src = format_r[UNFILT_BIT] ? i_sample.unfiltered : i_sample.filtered;
	assign rel = i_req.addr - ACCEL_DATA_BASE;

	always_comb begin
		live_nxt = live_r;
		msb_nxt = msb_r;
		lock_nxt = lock_r;
		for (int a = 0; a < 3; a++) begin
			if (i_sample_valid) begin
				live_nxt[a] = src[a];
				// Frozen MSB keeps the half that pairs with the LSB read
				if (!lock_r[a]) begin
					msb_nxt[a] = src[a][11:4];
				end
			end
			if (i_req.rd && rel == 8'(2 * a) && !format_r[LOCK_DIS_BIT]) begin
				lock_nxt[a] = 1'b1;
			end
			if (i_req.rd && rel == 8'(2 * a + 1)) begin
				lock_nxt[a] = 1'b0;
			end
			if (format_r[LOCK_DIS_BIT]) begin
				lock_nxt[a] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			live_r <= '0;
			msb_r <= '0;
			lock_r <= 3'h0;
		end else begin
			live_r <= live_nxt;
			msb_r <= msb_nxt;
			lock_r <= lock_nxt;
		end
	end

	// ==========================================
	// Read port
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (i_req.rd) begin
			if (i_req.addr == POWER_MODE_SELECT) begin
				rdata_nxt = power_r;
			end else if (i_req.addr == LOW_POWER_PROFILE) begin
				rdata_nxt = profile_r;
			end else if (i_req.addr == OUTPUT_DATA_FORMAT) begin
				rdata_nxt = format_r;
			end else if (i_req.addr == EVENT_ENABLE_GROUP0) begin
				rdata_nxt = enable_r;
			end else if (rel < 8'h06) begin
				if (rel[0]) begin
					rdata_nxt = msb_r[rel[2:1]];
				end else begin
					rdata_nxt = {live_r[rel[2:1]][3:0], 4'h0};
				end
			end else begin
				// Key register is write-only; unmapped reads give zero
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================
	// Outputs
	logic low_or_susp;

	assign low_or_susp = mode_r == PM_LOW_POWER || mode_r == PM_SUSPEND;
	assign o_reg_rdata = rdata_r;
	assign o_power_mode = mode_r;
	assign o_fast_access_profile = profile_r[PROFILE_BIT];
	assign o_fifo_access_en = !low_or_susp || profile_r[PROFILE_BIT];
	assign o_slow_write_required = low_or_susp && !profile_r[PROFILE_BIT];
	assign o_equidistant_timebase = equidistant;
	assign o_wake_pulse = wake_r;
	assign o_fifo_write = fifo_wr_r;
	assign o_soft_reset_busy = srst_busy_r;
	assign o_engine_enable = engine_enable_t'({enable_r[7:4], enable_r[2:0]});
	assign o_level_pose_valid = enable_r[7];
	assign o_level_pose_flag = i_level_pose_raw && enable_r[7];

endmodule // accel_power_cfg
